// >>> src/bit_toggle_and_flag_branch_exec.sv
/*
  Executor for bit toggle and the overflow / zero relative branches,
  with a small Avalon-MM register slave for control and observation.
  Assumes instr_i is the word at pc_o, held valid while wanted, and a
  data memory that returns read data the cycle after mem_rd_en_o.
  Opcodes other than these three are taken and otherwise ignored.
*/
// Local design decisions: the register offsets and register access over Avalon-MM.
//
// Functional notes
// RULE_01: Toggle reads byte, flips one bit, writes back
// RULE_02: Access bit clear uses access bank
// RULE_03: Access bit set uses bank select
// RULE_04: Indexed mode: a clear, extended, f<=95
// RULE_05: Overflow branch 1110 0100, taken on overflow
// RULE_06: Zero branch 1110 0000, taken on zero
// RULE_07: Target is incremented PC plus twice offset
// RULE_08: Branch one word, taken costs nop cycle
// RULE_09: Flags untouched; toggle read Q2, write Q4
// RULE_10: Untaken branch writes no PC
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_and_flag_branch_exec (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Instruction fetch
	input wire logic [15:0] instr_i,
	input wire logic instr_valid_i,
	output logic instr_taken_o,
	output logic [toggle_branch_pkg::PC_W-1:0] pc_o,
	// Status flags from the core
	input wire logic overflow_flag_i,
	input wire logic zero_flag_i,
	// Data memory
	output logic [toggle_branch_pkg::DADDR_W-1:0] mem_addr_o,
	output logic mem_rd_en_o,
	input wire logic [7:0] mem_rdata_i,
	output logic mem_we_o,
	output logic [7:0] mem_wdata_o,
	// Avalon-MM slave
	input wire logic [1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import toggle_branch_pkg::*;

	// Whole state of the executor
	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [3:0] bank;
		logic ext_en;
		logic [DADDR_W-1:0] idx_base;
		op_type op;
		logic [7:0] arg;
		logic [2:0] bitsel;
		logic [DADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic rd_en;
		logic we;
		logic flush;
		logic last_taken;
		logic instr_taken;
		logic wait_req;
		logic [31:0] rdata;
	} exec_state_type;

	exec_state_type st_q;
	exec_state_type st_d;
	phase_type phase;

	// Quarter sequencer
	quarter_phase_gen u_phase (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.phase_o(phase)
	);

	// Decode, execute and bus slave
	always_comb begin
		logic [7:0] f_addr;
		logic [31:0] mask;
		logic [31:0] merged;
		logic [31:0] cur;
		logic cond;
		f_addr = instr_i[7:0];
		mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		cur = 32'h0000_0000;
		merged = 32'h0000_0000;
		cond = 1'b0;
		st_d = st_q;
		st_d.instr_taken = 1'b0;
		st_d.rd_en = 1'b0;
		st_d.we = 1'b0;

		unique case (phase)
			PH_Q1: begin
				st_d.op = OP_NONE;
				if (st_q.flush) begin
					// RULE_08: taken branch nop cycle
					st_d.flush = 1'b0;
				end else if (instr_valid_i) begin
					st_d.instr_taken = 1'b1;
					// Counter moves on before execution
					st_d.pc = st_q.pc + PC_W'(2);
					st_d.arg = instr_i[7:0];
					st_d.bitsel = instr_i[BIT_LSB +: 3];
					if (instr_i[15:12] == TOGGLE_NIBBLE) begin
						st_d.op = OP_TOGGLE;
						// RULE_09: read issued for Q2
						st_d.rd_en = 1'b1;
						if (instr_i[ACC_POS]) begin
							// RULE_03: bank select chooses bank
							st_d.addr = {st_q.bank, f_addr};
						end else if (st_q.ext_en && f_addr <= INDEXED_TOP) begin
							// RULE_04: indexed literal offset
							st_d.addr = st_q.idx_base + {4'h0, f_addr};
						end else if (f_addr < ACCESS_SPLIT) begin
							// RULE_02: access bank, low half
							st_d.addr = {ACCESS_LOW_BANK, f_addr};
						end else begin
							// RULE_02: access bank, high half
							st_d.addr = {ACCESS_HIGH_BANK, f_addr};
						end
					// RULE_05: overflow branch decode
					end else if (instr_i[15:8] == BR_OVF_BYTE) begin
						st_d.op = OP_BR_OVF;
					// RULE_06: zero branch decode
					end else if (instr_i[15:8] == BR_ZERO_BYTE) begin
						st_d.op = OP_BR_ZERO;
					end
				end
			end
			PH_Q2: begin
				// Read data arrives next quarter
			end
			PH_Q3: begin
				if (st_q.op == OP_TOGGLE) begin
					// RULE_01: flip only selected bit
					st_d.wdata = mem_rdata_i ^ (8'h01 << st_q.bitsel);
					// RULE_09: write back in Q4
					st_d.we = 1'b1;
				end
				// RULE_05: overflow condition
				if (st_q.op == OP_BR_OVF) begin
					cond = overflow_flag_i;
				end
				// RULE_06: zero condition
				if (st_q.op == OP_BR_ZERO) begin
					cond = zero_flag_i;
				end
				if (st_q.op == OP_BR_OVF || st_q.op == OP_BR_ZERO) begin
					st_d.last_taken = cond;
				end
				if (cond) begin
					// RULE_07: incremented PC plus 2n
					st_d.pc = st_q.pc + {{(PC_W-9){st_q.arg[7]}}, st_q.arg, 1'b0};
					// RULE_08: discard next fetch
					st_d.flush = 1'b1;
				end
				// RULE_10: untaken branch leaves PC
			end
			PH_Q4: begin
				// RULE_09: status flags never driven
			end
		endcase

		// Slave: one wait cycle, then answer
		st_d.wait_req = 1'b1;
		if ((avs_read_i || avs_write_i) && st_q.wait_req) begin
			st_d.wait_req = 1'b0;
			unique case (avs_address_i)
				CTRL_IDX: begin
					cur = 32'h0000_0000;
					cur[CTRL_EXT_POS] = st_q.ext_en;
					cur[CTRL_BANK_LSB +: 4] = st_q.bank;
				end
				INDEX_IDX: cur = {20'h0_0000, st_q.idx_base};
				PC_IDX: cur = {11'h000, st_q.pc};
				STATUS_IDX: begin
					cur = 32'h0000_0000;
					cur[STAT_TAKEN_POS] = st_q.last_taken;
					cur[STAT_FLUSH_POS] = st_q.flush;
				end
			endcase
			st_d.rdata = avs_read_i ? cur : 32'h0000_0000;
			merged = (cur & ~mask) | (avs_writedata_i & mask);
			if (avs_write_i) begin
				unique case (avs_address_i)
					CTRL_IDX: begin
						st_d.ext_en = merged[CTRL_EXT_POS];
						st_d.bank = merged[CTRL_BANK_LSB +: 4];
					end
					INDEX_IDX: st_d.idx_base = merged[DADDR_W-1:0];
					// Software load beats a branch in the same cycle
					PC_IDX: st_d.pc = merged[PC_W-1:0];
					// Status is read only
					STATUS_IDX: begin
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q <= '{pc: PC_RESET, bank: BANK_RESET, ext_en: CTRL_EXT_RESET,
				idx_base: INDEX_RESET, op: OP_NONE, arg: 8'h00, bitsel: 3'h0,
				addr: 12'h000, wdata: 8'h00, rd_en: 1'b0, we: 1'b0, flush: 1'b0,
				last_taken: 1'b0, instr_taken: 1'b0, wait_req: 1'b1,
				rdata: 32'h0000_0000};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign instr_taken_o = st_q.instr_taken;
	assign pc_o = st_q.pc;
	assign mem_addr_o = st_q.addr;
	assign mem_rd_en_o = st_q.rd_en;
	assign mem_we_o = st_q.we;
	assign mem_wdata_o = st_q.wdata;
	assign avs_readdata_o = st_q.rdata;
	assign avs_waitrequest_o = st_q.wait_req;
endmodule
`default_nettype wire

// >>> src/btg_branch_pkg.sv
/*
  Shared constants and types for the bit toggle and flag branch executor.
  Assumes a 50 MHz system clock and a four-quarter instruction cycle.
*/
package toggle_branch_pkg;
	// Data and program widths
	localparam int PC_W = 21;
	localparam int DADDR_W = 12;
	// Opcode patterns, upper byte or upper nibble
	localparam logic [3:0] TOGGLE_NIBBLE = 4'h7;
	localparam logic [7:0] BR_OVF_BYTE = 8'hE4;
	localparam logic [7:0] BR_ZERO_BYTE = 8'hE0;
	// Field positions in the instruction word
	localparam int BIT_LSB = 9;
	localparam int ACC_POS = 8;
	// Literal offset window and access bank split
	localparam logic [7:0] INDEXED_TOP = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	// Register word indices on the slave bus
	localparam logic [1:0] CTRL_IDX = 2'h0;
	localparam logic [1:0] INDEX_IDX = 2'h1;
	localparam logic [1:0] PC_IDX = 2'h2;
	localparam logic [1:0] STATUS_IDX = 2'h3;
	// Control field positions and reset values
	localparam int CTRL_EXT_POS = 0;
	localparam int CTRL_BANK_LSB = 8;
	localparam logic CTRL_EXT_RESET = 1'b0;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] INDEX_RESET = 12'h000;
	localparam logic [20:0] PC_RESET = 21'h00_0000;
	// Status field positions
	localparam int STAT_TAKEN_POS = 0;
	localparam int STAT_FLUSH_POS = 1;
	// Quarter phases, Gray coded
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_type;
	// Decoded operation
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_TOGGLE = 2'b01,
		OP_BR_OVF = 2'b11,
		OP_BR_ZERO = 2'b10
	} op_type;
endpackage

// >>> src/quarter_phase_gen.sv
/*
  Quarter phase sequencer: walks Q1..Q4 once per four system clocks.
  Assumes a synchronous active-high reset shared with the executor.
*/
`timescale 1ns/1ps
`default_nettype none
module quarter_phase_gen (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Current quarter
	output var toggle_branch_pkg::phase_type phase_o
);
	import toggle_branch_pkg::*;

	// Whole state of the sequencer
	typedef struct packed {
		phase_type phase;
	} seq_state_type;

	seq_state_type seq_q;
	seq_state_type seq_d;

	// Next quarter along the Gray path
	always_comb begin
		seq_d = seq_q;
		unique case (seq_q.phase)
			PH_Q1: seq_d.phase = PH_Q2;
			PH_Q2: seq_d.phase = PH_Q3;
			PH_Q3: seq_d.phase = PH_Q4;
			PH_Q4: seq_d.phase = PH_Q1;
		endcase
	end

	// Register, Q1 after reset
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			seq_q <= '{phase: PH_Q1};
		end else begin
			seq_q <= seq_d;
		end
	end

	assign phase_o = seq_q.phase;
endmodule
`default_nettype wire

// >>> testbench/btg_exec_monitor.sv
/*
  Port checker for the toggle and branch executor.
  Assumes it is bound to the executor top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module toggle_exec_monitor (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Fetch side
	input wire logic instr_taken_o,
	input wire logic [toggle_branch_pkg::PC_W-1:0] pc_o,
	// Data memory side
	input wire logic [toggle_branch_pkg::DADDR_W-1:0] mem_addr_o,
	input wire logic mem_rd_en_o,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_we_o,
	input wire logic [7:0] mem_wdata_o,
	// Register bus
	input wire logic avs_waitrequest_o
);
	import toggle_branch_pkg::*;
	// One domain, so one clock and one reset for all
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// Read in Q2 is always followed by write-back in Q4
	chk_rd_then_wr: assert property (mem_rd_en_o |-> ##2 mem_we_o)
		else $error("write-back not two cycles after read");
	chk_one_bit: assert property (mem_we_o |-> $countones(mem_wdata_o ^ $past(mem_rdata_i)) == 1)
		else $error("write-back differs in other than one bit");
	chk_same_addr: assert property (mem_we_o |-> mem_addr_o == $past(mem_addr_o, 2))
		else $error("write-back address moved");
	chk_rd_in_q2: assert property (mem_rd_en_o |-> instr_taken_o)
		else $error("read not in the take cycle");
	// Wrap kept to the counter width
	chk_take_pc: assert property (instr_taken_o |-> pc_o == PC_W'($past(pc_o) + 2))
		else $error("counter not stepped by two on take");
	chk_take_gap: assert property (instr_taken_o |=> !instr_taken_o [*3])
		else $error("words taken closer than a cycle");
	chk_flush_gap: assert property (instr_taken_o ##2 $changed(pc_o) |=> !instr_taken_o [*5])
		else $error("no idle cycle after a jump");
	chk_pc_cause: assert property ($changed(pc_o) |-> instr_taken_o || $past(instr_taken_o, 2) || !avs_waitrequest_o)
		else $error("counter moved without cause");
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/*
  Bench for the toggle and branch executor.
  Assumes the package, design and monitor compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import toggle_branch_pkg::*;
	// Stimulus and responses
	logic sys_clk_i = 0, srst_i = 1, instr_valid_i = 0, overflow_flag_i = 0, zero_flag_i = 0;
	logic avs_read_i = 0, avs_write_i = 0, instr_taken_o, mem_rd_en_o, mem_we_o, avs_waitrequest_o;
	logic [15:0] instr_i = 16'h0000;
	logic [PC_W-1:0] pc_o, p;
	logic [DADDR_W-1:0] mem_addr_o, wa;
	logic [7:0] mem_rdata_i = 8'h00, mem_wdata_o, wd, mval = 8'h75;
	logic [1:0] avs_address_i = 2'h0;
	logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
	int n_fail = 0, checked = 0, cyc = 0;
	// 50 MHz clock
	always #10 sys_clk_i = ~sys_clk_i;
	// Memory answers one cycle after a read, scrambled otherwise
	always @(posedge sys_clk_i) begin
		mem_rdata_i <= mem_rd_en_o ? mval : ~mem_rdata_i;
		if (mem_we_o === 1'b1) begin
			wa <= mem_addr_o;
			wd <= mem_wdata_o;
		end
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			conclude();
		end
	end
	bit_toggle_and_flag_branch_exec DUT (.sys_clk_i, .srst_i, .instr_i, .instr_valid_i, .instr_taken_o, .pc_o,
		.overflow_flag_i, .zero_flag_i, .mem_addr_o, .mem_rd_en_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
		.avs_readdata_o, .avs_waitrequest_o);
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Bus cycle held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	// One word, then room for a jump and its idle cycle
	task automatic exec(input logic [15:0] ins, input logic ov, z);
		instr_i <= ins;
		overflow_flag_i <= ov;
		zero_flag_i <= z;
		instr_valid_i <= 1'b1;
		do @(posedge sys_clk_i); while (instr_taken_o !== 1'b1);
		instr_valid_i <= 1'b0;
		repeat (10) @(posedge sys_clk_i);
	endtask
	// Flags set high so a toggle that branched would show
	task automatic tog(input logic [15:0] ins, input logic [11:0] ea, input logic [7:0] ed);
		exec(ins, 1'b1, 1'b1);
		// Model counter: one word consumed, no jump
		p = PC_W'(p + 2);
		check("addr", wa, ea);
		check("data", wd, ed);
		check("pc", pc_o, p);
	endtask
	task automatic br(input logic [15:0] ins, input logic ov, z, input int off);
		exec(ins, ov, z);
		// Model counter: incremented PC plus any jump
		p = PC_W'(p + 2 + off);
		check("pc", pc_o, p);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		// Model counter starts from the reset value
		p = PC_RESET;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		bus(1'b0, CTRL_IDX, 32'h0000_0000);
		check("ctrl", q, 32'h0000_0000);
		bus(1'b1, CTRL_IDX, 32'h0000_0300);
		tog(16'h7925, 12'h325, 8'h65);
		tog(16'h7025, 12'h025, 8'h74);
		tog(16'h7E90, 12'hF90, 8'hF5);
		// Extension on, index base 0x100
		bus(1'b1, INDEX_IDX, 32'h0000_0100);
		bus(1'b1, CTRL_IDX, 32'h0000_0301);
		bus(1'b0, INDEX_IDX, 32'h0000_0000);
		check("index", q, 32'h0000_0100);
		bus(1'b0, CTRL_IDX, 32'h0000_0000);
		check("ctrl", q, 32'h0000_0301);
		tog(16'h725F, 12'h15F, 8'h77);
		tog(16'h7260, 12'h060, 8'h77);
		tog(16'h7310, 12'h310, 8'h77);
		$display("toggle test done");
		bus(1'b1, PC_IDX, 32'h0000_1000);
		p = PC_W'(32'h0000_1000);
		br(16'hE480, 1'b1, 1'b0, -256);
		// Last branch taken, its idle cycle already spent
		bus(1'b0, STATUS_IDX, 32'h0000_0000);
		check("status", q, 32'h0000_0001);
		br(16'hE47F, 1'b0, 1'b1, 0);
		bus(1'b0, STATUS_IDX, 32'h0000_0000);
		check("status", q, 32'h0000_0000);
		br(16'hE07F, 1'b0, 1'b1, 254);
		br(16'hE080, 1'b1, 1'b0, 0);
		br(16'hE180, 1'b1, 1'b1, 0);
		bus(1'b0, PC_IDX, 32'h0000_0000);
		check("pcreg", q, p);
		$display("branch test done");
		conclude();
	end
endmodule
bind bit_toggle_and_flag_branch_exec toggle_exec_monitor MON (.sys_clk_i, .srst_i, .instr_taken_o, .pc_o,
	.mem_addr_o, .mem_rd_en_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o, .avs_waitrequest_o);
`default_nettype wire
